/* File: rtl/iwd_pkg.sv */
package iwd_pkg;

  localparam int WORD_W = 24;
  localparam int OPC_W = 8;
  localparam int OPC_LSB = 16;
  localparam int OPS_W = 16;
  localparam int REG_W = 4;
  localparam int MODE_W = 2;
  localparam int MADDR_W = 13;
  localparam int LIT_W = 16;
  localparam int PADDR_W = 23;
  localparam int PADDR_HI_W = 7;
  localparam int CNT_W = 2;

  // Operand field positions inside the low 16 bits of a word
  localparam int BASE_LSB = 12;
  localparam int DEST_LSB = 8;
  localparam int DMODE_LSB = 6;
  localparam int SMODE_LSB = 4;
  localparam int SRC_LSB = 0;
  localparam int MADDR_LSB = 0;
  localparam int MWR_BIT = 13;
  localparam int MBIT_LSB = 13;
  localparam int MBIT_W = 3;
  localparam int ALIT_LSB = 4;
  localparam int ALIT_W = 8;
  localparam int MLIT_W = 12;
  localparam int TMODE_LSB = 0;

  // The only two-word opcodes, then the required top byte of a second word
  localparam logic [OPC_W-1:0] OPC_GOTO = 8'hc0;
  localparam logic [OPC_W-1:0] OPC_CALL = 8'hc1;
  localparam logic [OPC_W-1:0] OPC_MOVLM = 8'hc2;
  localparam logic [OPC_W-1:0] EXT_TOP = 8'h00;

  localparam logic [REG_W-1:0] DEFAULT_WORK_REG = 4'h0;

  // Inserted cycles beyond the discarded prefetch
  localparam logic [CNT_W-1:0] STALL_TABLE = 2'h1;
  localparam logic [CNT_W-1:0] STALL_RETURN = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;

  typedef enum logic [3:0] {
    CLS_NOP = 4'h0,
    CLS_DEFAULT_WORK_REG = 4'h1,
    CLS_MEM = 4'h2,
    CLS_BIT = 4'h3,
    CLS_LIT_AR = 4'h4,
    CLS_LIT_MV = 4'h5,
    CLS_COND_BR = 4'h6,
    CLS_SKIP = 4'h7,
    CLS_BRANCH = 4'h8,
    CLS_TABLE = 4'h9,
    CLS_RETURN = 4'ha,
    CLS_MOVD = 4'hb,
    CLS_TWO = 4'hc
  } iwd_class_type;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b10
  } iwd_state_type;

endpackage

/* File: rtl/iwd_word_class.sv */
`timescale 1ns/1ps
module iwd_word_class import iwd_pkg::*; (
  input wire logic [WORD_W-1:0] word,
  output iwd_class_type cls,
  output logic two_word
);

  logic [OPC_W-1:0] opc;

  assign opc = word[WORD_W-1:OPC_LSB];

  always_comb begin
    two_word = (opc == OPC_GOTO) || (opc == OPC_CALL) || (opc == OPC_MOVLM);
    unique case (opc[7:4])
      4'h0: cls = CLS_NOP;
      4'h1: cls = CLS_DEFAULT_WORK_REG;
      4'h2: cls = CLS_MEM;
      4'h3: cls = CLS_BIT;
      4'h4: cls = CLS_LIT_AR;
      4'h5: cls = CLS_LIT_MV;
      4'h6: cls = CLS_COND_BR;
      4'h7: cls = CLS_SKIP;
      4'h8: cls = CLS_BRANCH;
      4'h9: cls = CLS_TABLE;
      4'ha: cls = CLS_RETURN;
      4'hb: cls = CLS_MOVD;
      4'hc: cls = two_word ? CLS_TWO : CLS_NOP;
      default: cls = CLS_NOP;
    endcase
  end

endmodule

/* File: rtl/iwd_decoder.sv */
// Operation
// RULE1: Each ordinary instruction is one 24-bit program word.
// RULE2: Upper 8 bits are the opcode; lower bits carry operand fields.
// RULE3: Only three opcodes span two consecutive words; all others one.
// RULE4: Two-word instruction is 48 bits; second word top 8 bits must be zero.
// RULE5: A stray second word executes as a no-operation.
// RULE6: Single-word takes one cycle; taken test or PC change adds a NOP cycle.
// RULE7: Branches, indirect call/jump, table ops and returns take two or three cycles.
// RULE8: Taken skip takes two cycles, three when skipping a two-word instruction.
// RULE9: Double-word moves take two cycles.
// RULE10: Two-word instructions complete in two cycles.
// RULE11: Register ops decode base, source with mode, destination with mode.
// RULE12: Memory ops decode address and write back to memory or register 0.
// RULE13: Bit ops target register or memory; bit from literal or base register.
// RULE14: Literal arithmetic uses base and literal; separate destination only if encoded.
// RULE15: Literal moves load a register or memory location.
// RULE16: Control ops decode a program address or table mode.
// RULE17: Register fields select one of sixteen working registers.
// RULE18: Memory address field spans 0x0000 to 0x1fff.
// RULE19: Prefetched word after a taken branch or skip is discarded.
`timescale 1ns/1ps
module iwd_decoder import iwd_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic word_valid,
  input wire logic [WORD_W-1:0] word_data,
  output logic word_ready,
  input wire logic cond_true,
  output logic exec_redirect,
  output logic exec_valid,
  output logic exec_nop,
  output iwd_class_type exec_class,
  output logic [OPC_W-1:0] exec_opcode,
  output logic exec_double,
  output logic exec_ext_err,
  output logic [REG_W-1:0] exec_base_reg,
  output logic [REG_W-1:0] exec_src_reg,
  output logic [MODE_W-1:0] exec_src_mode,
  output logic [REG_W-1:0] exec_dest_reg,
  output logic [MODE_W-1:0] exec_dest_mode,
  output logic exec_write_dest,
  output logic [MADDR_W-1:0] exec_mem_addr,
  output logic exec_use_mem,
  output logic exec_wr_mem,
  output logic [REG_W-1:0] exec_bit_num,
  output logic exec_bit_from_reg,
  output logic [LIT_W-1:0] exec_literal,
  output logic [PADDR_W-1:0] exec_prog_addr,
  output logic [MODE_W-1:0] exec_table_mode,
  output logic exec_int_return
);

  iwd_state_type state_reg;
  iwd_class_type in_cls;
  iwd_class_type cls_d;
  logic in_two;
  logic [WORD_W-1:0] first_reg;
  logic [CNT_W-1:0] drop_cnt_reg;
  logic [CNT_W-1:0] drop_cnt_next;
  logic [CNT_W-1:0] stall_cnt_reg;
  logic skip_chain_reg;
  logic skip_now;
  logic taken;
  logic movd_hold;
  logic stall;
  logic accept;
  logic dropping;
  logic drop_word;
  logic take_word;
  logic skip_ext;
  logic issue;
  logic nop_next;

  logic exec_valid_reg;
  logic exec_nop_reg;
  iwd_class_type exec_cls_reg;
  logic [OPC_W-1:0] exec_opcode_reg;
  logic exec_double_reg;
  logic exec_ext_err_reg;
  logic [REG_W-1:0] exec_base_reg_reg;
  logic [REG_W-1:0] exec_src_reg_reg;
  logic [MODE_W-1:0] exec_src_mode_reg;
  logic [REG_W-1:0] exec_dest_reg_reg;
  logic [MODE_W-1:0] exec_dest_mode_reg;
  logic exec_write_dest_reg;
  logic [MADDR_W-1:0] exec_mem_addr_reg;
  logic exec_use_mem_reg;
  logic exec_wr_mem_reg;
  logic [REG_W-1:0] exec_bit_num_reg;
  logic exec_bit_from_reg_reg;
  logic [LIT_W-1:0] exec_literal_reg;
  logic [PADDR_W-1:0] exec_prog_addr_reg;
  logic [MODE_W-1:0] exec_table_mode_reg;
  logic exec_int_return_reg;

  logic [WORD_W-1:0] cur;
  logic [OPC_W-1:0] opc;
  logic [OPS_W-1:0] ops;
  logic [REG_W-1:0] d_base;
  logic [REG_W-1:0] d_src;
  logic [MODE_W-1:0] d_smode;
  logic [REG_W-1:0] d_dest;
  logic [MODE_W-1:0] d_dmode;
  logic d_wdest;
  logic [MADDR_W-1:0] d_maddr;
  logic d_use_mem;
  logic d_wr_mem;
  logic [REG_W-1:0] d_bitn;
  logic d_bit_reg;
  logic [LIT_W-1:0] d_lit;
  logic [PADDR_W-1:0] d_paddr;
  logic [MODE_W-1:0] d_tmode;
  logic d_int_ret;
  logic d_double;
  logic d_ext_err;

  iwd_word_class u_class (
    .word(word_data),
    .cls(in_cls),
    .two_word(in_two)
  );

  // Cycle timing and prefetch handling
  always_comb begin
    skip_now = exec_valid_reg && (exec_cls_reg == CLS_SKIP) && cond_true;
    taken = exec_valid_reg && ((((exec_cls_reg == CLS_COND_BR) || (exec_cls_reg == CLS_SKIP)) && cond_true) ||
            (exec_cls_reg == CLS_BRANCH) || (exec_cls_reg == CLS_TABLE) || (exec_cls_reg == CLS_RETURN)); // see RULE6
    movd_hold = exec_valid_reg && (exec_cls_reg == CLS_MOVD); // see RULE9
    stall = (stall_cnt_reg != CNT_ZERO) && (drop_cnt_reg == CNT_ZERO); // see RULE7
    word_ready = !stall && !movd_hold;
    accept = word_valid && word_ready;
    dropping = taken || (drop_cnt_reg != CNT_ZERO);
    drop_word = accept && dropping; // see RULE19
    take_word = accept && !dropping;
    skip_ext = drop_word && in_two && (skip_now || skip_chain_reg); // see RULE8
    drop_cnt_next = drop_cnt_reg + {1'b0, taken} - {1'b0, drop_word} + {1'b0, skip_ext};
    issue = take_word && ((state_reg == ST_SECOND) || (!in_two && (in_cls != CLS_NOP))); // see RULE3
    nop_next = drop_word || stall || movd_hold || (take_word && (state_reg == ST_FIRST) && (in_cls == CLS_NOP)); // see RULE5
  end

  assign exec_redirect = taken;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt_reg <= CNT_ZERO;
      skip_chain_reg <= 1'b0;
    end else begin
      drop_cnt_reg <= drop_cnt_next;
      if (drop_word) begin
        skip_chain_reg <= 1'b0;
      end else if (skip_now) begin
        skip_chain_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_reg <= CNT_ZERO;
    end else if (taken && (exec_cls_reg == CLS_TABLE)) begin
      stall_cnt_reg <= STALL_TABLE; // see RULE7
    end else if (taken && (exec_cls_reg == CLS_RETURN)) begin
      stall_cnt_reg <= STALL_RETURN; // see RULE7
    end else if (stall) begin
      stall_cnt_reg <= stall_cnt_reg - CNT_ONE;
    end
  end

  // Two-word sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_FIRST;
      first_reg <= '0;
    end else if (take_word) begin
      unique case (state_reg)
        ST_FIRST: begin
          if (in_two) begin
            state_reg <= ST_SECOND; // see RULE10
            first_reg <= word_data;
          end
        end
        ST_SECOND: state_reg <= ST_FIRST;
        default: state_reg <= ST_FIRST;
      endcase
    end
  end

  // Operand field decode
  always_comb begin
    cur = (state_reg == ST_SECOND) ? first_reg : word_data; // see RULE1
    cls_d = (state_reg == ST_SECOND) ? CLS_TWO : in_cls;
    opc = cur[WORD_W-1:OPC_LSB]; // see RULE2
    ops = cur[OPS_W-1:0];
    d_base = ops[BASE_LSB +: REG_W]; // see RULE17
    d_src = ops[SRC_LSB +: REG_W];
    d_smode = ops[SMODE_LSB +: MODE_W];
    d_dest = ops[DEST_LSB +: REG_W];
    d_dmode = ops[DMODE_LSB +: MODE_W];
    d_wdest = 1'b0;
    d_maddr = ops[MADDR_LSB +: MADDR_W]; // see RULE18
    d_use_mem = 1'b0;
    d_wr_mem = 1'b0;
    d_bitn = '0;
    d_bit_reg = 1'b0;
    d_lit = '0;
    d_paddr = '0;
    d_tmode = ops[TMODE_LSB +: MODE_W];
    d_int_ret = 1'b0;
    d_double = 1'b0;
    d_ext_err = 1'b0;
    unique case (cls_d)
      CLS_NOP: d_wdest = 1'b0;
      CLS_DEFAULT_WORK_REG, CLS_MOVD: d_wdest = 1'b1; // see RULE11
      CLS_MEM: begin
        d_use_mem = 1'b1;
        d_wr_mem = ops[MWR_BIT];
        d_dest = DEFAULT_WORK_REG; // see RULE12
        d_wdest = !ops[MWR_BIT];
      end
      CLS_BIT, CLS_SKIP: begin
        d_use_mem = opc[0]; // see RULE13
        d_bit_reg = opc[1] && !opc[0];
        d_bitn = opc[0] ? {1'b0, ops[MBIT_LSB +: MBIT_W]} : ops[DEST_LSB +: REG_W];
      end
      CLS_LIT_AR: begin
        d_lit = {{(LIT_W-ALIT_W){1'b0}}, ops[ALIT_LSB +: ALIT_W]};
        d_wdest = opc[0]; // see RULE14
        d_dest = opc[0] ? ops[SRC_LSB +: REG_W] : d_base;
      end
      CLS_LIT_MV: begin
        d_lit = {{(LIT_W-MLIT_W){1'b0}}, ops[MLIT_W-1:0]}; // see RULE15
        d_dest = d_base;
        d_wdest = 1'b1;
      end
      CLS_COND_BR, CLS_BRANCH: d_paddr = {{(PADDR_W-OPS_W){1'b0}}, ops}; // see RULE16
      CLS_TABLE: d_tmode = ops[TMODE_LSB +: MODE_W]; // see RULE16
      CLS_RETURN: d_int_ret = opc[0];
      CLS_TWO: begin
        d_double = 1'b1;
        d_ext_err = word_data[WORD_W-1:OPC_LSB] != EXT_TOP; // see RULE4
        if (opc == OPC_MOVLM) begin
          d_use_mem = 1'b1; // see RULE15
          d_wr_mem = 1'b1;
          d_lit = word_data[LIT_W-1:0];
        end else begin
          d_paddr = {word_data[PADDR_HI_W-1:0], ops}; // see RULE16
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_valid_reg <= 1'b0;
      exec_nop_reg <= 1'b0;
    end else begin
      exec_valid_reg <= issue;
      exec_nop_reg <= nop_next; // see RULE6
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_cls_reg <= CLS_NOP;
      exec_opcode_reg <= '0;
      exec_double_reg <= 1'b0;
      exec_ext_err_reg <= 1'b0;
      exec_base_reg_reg <= '0;
      exec_src_reg_reg <= '0;
      exec_src_mode_reg <= '0;
      exec_dest_reg_reg <= '0;
      exec_dest_mode_reg <= '0;
      exec_write_dest_reg <= 1'b0;
      exec_mem_addr_reg <= '0;
      exec_use_mem_reg <= 1'b0;
      exec_wr_mem_reg <= 1'b0;
      exec_bit_num_reg <= '0;
      exec_bit_from_reg_reg <= 1'b0;
      exec_literal_reg <= '0;
      exec_prog_addr_reg <= '0;
      exec_table_mode_reg <= '0;
      exec_int_return_reg <= 1'b0;
    end else if (issue) begin
      exec_cls_reg <= cls_d;
      exec_opcode_reg <= opc;
      exec_double_reg <= d_double;
      exec_ext_err_reg <= d_ext_err;
      exec_base_reg_reg <= d_base;
      exec_src_reg_reg <= d_src;
      exec_src_mode_reg <= d_smode;
      exec_dest_reg_reg <= d_dest;
      exec_dest_mode_reg <= d_dmode;
      exec_write_dest_reg <= d_wdest;
      exec_mem_addr_reg <= d_maddr;
      exec_use_mem_reg <= d_use_mem;
      exec_wr_mem_reg <= d_wr_mem;
      exec_bit_num_reg <= d_bitn;
      exec_bit_from_reg_reg <= d_bit_reg;
      exec_literal_reg <= d_lit;
      exec_prog_addr_reg <= d_paddr;
      exec_table_mode_reg <= d_tmode;
      exec_int_return_reg <= d_int_ret;
    end
  end

  assign exec_valid = exec_valid_reg;
  assign exec_nop = exec_nop_reg;
  assign exec_class = exec_cls_reg;
  assign exec_opcode = exec_opcode_reg;
  assign exec_double = exec_double_reg;
  assign exec_ext_err = exec_ext_err_reg;
  assign exec_base_reg = exec_base_reg_reg;
  assign exec_src_reg = exec_src_reg_reg;
  assign exec_src_mode = exec_src_mode_reg;
  assign exec_dest_reg = exec_dest_reg_reg;
  assign exec_dest_mode = exec_dest_mode_reg;
  assign exec_write_dest = exec_write_dest_reg;
  assign exec_mem_addr = exec_mem_addr_reg;
  assign exec_use_mem = exec_use_mem_reg;
  assign exec_wr_mem = exec_wr_mem_reg;
  assign exec_bit_num = exec_bit_num_reg;
  assign exec_bit_from_reg = exec_bit_from_reg_reg;
  assign exec_literal = exec_literal_reg;
  assign exec_prog_addr = exec_prog_addr_reg;
  assign exec_table_mode = exec_table_mode_reg;
  assign exec_int_return = exec_int_return_reg;

  // Checks
  AST_STRAY_SECOND_NOP: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE5
    (state_reg == ST_FIRST && take_word && word_data[WORD_W-1:OPC_LSB] == EXT_TOP) |=>
      exec_nop_reg && !exec_valid_reg)
    else $error("Stray second word did not execute as a no-operation");
  AST_TWO_WORD_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE3
    (state_reg == ST_FIRST && take_word && in_two) |=> state_reg == ST_SECOND && !exec_valid_reg)
    else $error("Two-word first word did not wait for its second word");
  AST_SECOND_TOP_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE4
    (state_reg == ST_SECOND && take_word) |=>
      exec_valid_reg && exec_double_reg && (exec_ext_err_reg == ($past(word_data[WORD_W-1:OPC_LSB]) != EXT_TOP)))
    else $error("Second word check wrong");
  AST_BRANCH_FLUSH: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE19
    (exec_valid_reg && exec_cls_reg == CLS_COND_BR && cond_true && word_valid) |=> !exec_valid_reg && exec_nop_reg)
    else $error("Prefetched word not discarded after taken branch");
  AST_RETURN_THREE: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE7
    (exec_valid_reg && exec_cls_reg == CLS_RETURN && word_valid) |=>
      (exec_nop_reg && !word_ready) ##1 (exec_nop_reg && !exec_valid_reg))
    else $error("Return did not take three cycles");
  AST_SKIP_TWO_WORD: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE8
    (skip_now && word_valid && in_two) |=> drop_cnt_reg == CNT_ONE && exec_nop_reg)
    else $error("Skip over two-word instruction did not extend");
  AST_MOVD_TWO: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE9
    (exec_valid_reg && exec_cls_reg == CLS_MOVD) |-> !word_ready ##1 (exec_nop_reg && !exec_valid_reg))
    else $error("Double move did not take two cycles");
  AST_SINGLE_ONE: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE6
    (exec_valid_reg && exec_cls_reg == CLS_DEFAULT_WORK_REG && take_word && state_reg == ST_FIRST && !in_two
      && in_cls != CLS_NOP) |=> exec_valid_reg)
    else $error("Single-word instruction took more than one cycle");
  AST_MEM_DEFAULT: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE12
    (exec_valid_reg && exec_cls_reg == CLS_MEM && !exec_wr_mem_reg) |->
      exec_dest_reg_reg == DEFAULT_WORK_REG && exec_write_dest_reg)
    else $error("Memory op result not routed to register 0");
  AST_LIT_DEST: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE14
    (exec_valid_reg && exec_cls_reg == CLS_LIT_AR && !exec_opcode_reg[0]) |->
      exec_dest_reg_reg == exec_base_reg_reg && !exec_write_dest_reg)
    else $error("Literal arithmetic destination wrong");

endmodule

/* File: verification/iwd_fetch_model.sv */
`timescale 1ns/1ps
module iwd_fetch_model import iwd_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic word_ready,
  output logic word_valid,
  output logic [WORD_W-1:0] word_data
);
  logic [WORD_W-1:0] pend [$];
  logic taken;

  // Queue of program words offered in order, one per accepted cycle
  task automatic push(input logic [WORD_W-1:0] w);
    pend.push_back(w);
  endtask

  // Offer changes just after the edge; idle data toggles so stale words never look valid
  initial begin
    word_valid = 1'b0;
    word_data = 24'h000000;
    taken = 1'b0;
    forever begin
      @(posedge core_clk);
      taken = word_valid && word_ready && rst_n;
      #1;
      if (!rst_n) begin
        pend.delete();
      end else if (taken) begin
        void'(pend.pop_front());
      end
      if (pend.size() > 0) begin
        word_valid = 1'b1;
        word_data = pend[0];
      end else begin
        word_valid = 1'b0;
        word_data = ~word_data;
      end
    end
  end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top import iwd_pkg::*;;
  logic core_clk, rst_n, word_valid, word_ready, cond_true, exec_redirect, exec_valid, exec_nop;
  logic [WORD_W-1:0] word_data;
  iwd_class_type exec_class;
  logic [OPC_W-1:0] exec_opcode;
  logic exec_double, exec_ext_err, exec_write_dest, exec_use_mem, exec_wr_mem, exec_bit_from_reg, exec_int_return;
  logic [REG_W-1:0] exec_base_reg, exec_src_reg, exec_dest_reg, exec_bit_num;
  logic [MODE_W-1:0] exec_src_mode, exec_dest_mode, exec_table_mode;
  logic [MADDR_W-1:0] exec_mem_addr;
  logic [LIT_W-1:0] exec_literal;
  logic [PADDR_W-1:0] exec_prog_addr;
  int n_fail = 0;
  int check_count = 0;

  iwd_decoder dut_u (.core_clk(core_clk), .rst_n(rst_n), .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready), .cond_true(cond_true), .exec_redirect(exec_redirect), .exec_valid(exec_valid),
    .exec_nop(exec_nop), .exec_class(exec_class), .exec_opcode(exec_opcode), .exec_double(exec_double),
    .exec_ext_err(exec_ext_err), .exec_base_reg(exec_base_reg), .exec_src_reg(exec_src_reg),
    .exec_src_mode(exec_src_mode), .exec_dest_reg(exec_dest_reg), .exec_dest_mode(exec_dest_mode),
    .exec_write_dest(exec_write_dest), .exec_mem_addr(exec_mem_addr), .exec_use_mem(exec_use_mem),
    .exec_wr_mem(exec_wr_mem), .exec_bit_num(exec_bit_num), .exec_bit_from_reg(exec_bit_from_reg),
    .exec_literal(exec_literal), .exec_prog_addr(exec_prog_addr), .exec_table_mode(exec_table_mode),
    .exec_int_return(exec_int_return));

  iwd_fetch_model fetch_u (.core_clk(core_clk), .rst_n(rst_n), .word_ready(word_ready),
    .word_valid(word_valid), .word_data(word_data));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_str(input string got, input string exp);
    check_count++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH at %0t: cycle trace %s, expected %s", $time, got, exp);
    end
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: field %h, expected %h", $time, got, exp);
    end
  endtask

  // Trace letters: R redirecting issue, V issue, N no-operation cycle, B both at once
  task automatic play(input logic [WORD_W-1:0] w [$], input logic ct, input string exp);
    string s;
    int a, b;
    @(posedge core_clk);
    #1;
    cond_true = ct;
    foreach (w[i]) fetch_u.push(w[i]);
    s = "";
    repeat (14) begin
      @(negedge core_clk);
      if (exec_valid === 1'b1 && exec_nop === 1'b1) s = {s, "B"};
      else if (exec_valid === 1'b1 && exec_redirect === 1'b1) s = {s, "R"};
      else if (exec_valid === 1'b1) s = {s, "V"};
      else if (exec_nop === 1'b1) s = {s, "N"};
      else s = {s, "."};
    end
    a = 0;
    b = s.len() - 1;
    while (a < s.len() && s[a] == ".") a++;
    while (b >= a && s[b] == ".") b--;
    check_str(s.substr(a, b), exp);
  endtask

  task automatic t_single();
    play('{24'h10a5c7, 24'h101234}, 1'b1, "VV");
    check_val(32'(exec_class), 32'(CLS_DEFAULT_WORK_REG));
    check_val(32'(exec_opcode), 32'h10);
    check_val({exec_base_reg, exec_dest_reg, exec_src_reg}, 32'h124);
    check_val({exec_dest_mode, exec_src_mode}, 32'h3);
    play('{24'h10fcff}, 1'b0, "V");
    check_val({exec_base_reg, exec_dest_reg, exec_src_reg}, 32'hfcf);
    $display("t_single done");
  endtask

  task automatic t_cond();
    play('{24'h600000, 24'h100001, 24'h100002}, 1'b0, "VVV");
    play('{24'h600000, 24'h100009, 24'h100002}, 1'b1, "RNV");
    check_val(32'(exec_src_reg), 32'h2);
    $display("t_cond done");
  endtask

  task automatic t_flow();
    play('{24'h800000, 24'h100001, 24'h100003}, 1'b0, "RNV");
    play('{24'h900002, 24'h100001}, 1'b0, "RNN");
    check_val(32'(exec_table_mode), 32'h2);
    play('{24'ha10000, 24'h100001, 24'h100004}, 1'b0, "RNNV");
    check_val(32'(exec_src_reg), 32'h4);
    play('{24'h8abcde, 24'h100001}, 1'b0, "RN");
    check_val(32'(exec_prog_addr), 32'h00bcde);
    play('{24'ha10000, 24'h100001}, 1'b0, "RNN");
    check_val(32'(exec_class), 32'(CLS_RETURN));
    check_val(32'(exec_int_return), 32'h1);
    $display("t_flow done");
  endtask

  task automatic t_skip();
    play('{24'h700000, 24'h100001, 24'h100003}, 1'b1, "RNV");
    play('{24'h700000, 24'hc00000, 24'h000000, 24'h100005}, 1'b1, "RNNV");
    check_val(32'(exec_src_reg), 32'h5);
    play('{24'h700000, 24'h100006}, 1'b0, "VV");
    $display("t_skip done");
  endtask

  task automatic t_movd();
    play('{24'hb00000, 24'h100007}, 1'b0, "VNV");
    $display("t_movd done");
  endtask

  task automatic t_two();
    play('{24'hc04566, 24'h000055}, 1'b0, "V");
    check_val({exec_double, exec_ext_err}, 32'h2);
    check_val(32'(exec_prog_addr), 32'h554566);
    play('{24'hc21fff, 24'h00beef}, 1'b0, "V");
    check_val({exec_mem_addr, exec_literal}, {3'h0, 13'h1fff, 16'hbeef});
    play('{24'hc10000, 24'h120000}, 1'b0, "V");
    check_val({exec_opcode, exec_ext_err}, 32'h183);
    play('{24'hc00000, 24'h000000, 24'h100008}, 1'b0, "VV");
    play('{24'h001234, 24'h050000}, 1'b0, "NN");
    $display("t_two done");
  endtask

  task automatic t_fields();
    play('{24'h203fff}, 1'b0, "V");
    check_val({exec_use_mem, exec_wr_mem, exec_mem_addr}, 32'h7fff);
    play('{24'h201234}, 1'b0, "V");
    check_val({exec_wr_mem, exec_mem_addr}, 32'h1234);
    check_val(32'(exec_dest_reg), 32'(DEFAULT_WORK_REG));
    play('{24'h407ab5}, 1'b0, "V");
    check_val({exec_write_dest, exec_dest_reg, exec_base_reg, exec_literal}, 32'h7700ab);
    play('{24'h417ab5}, 1'b0, "V");
    check_val({exec_write_dest, exec_dest_reg}, 32'h15);
    play('{24'h503abc}, 1'b0, "V");
    check_val({exec_base_reg, exec_literal}, 32'h30abc);
    play('{24'h300a05}, 1'b0, "V");
    check_val({exec_use_mem, exec_bit_from_reg, exec_bit_num, exec_src_reg}, 32'ha5);
    play('{24'h32c005}, 1'b0, "V");
    check_val({exec_use_mem, exec_bit_from_reg}, 32'h1);
    play('{24'h31a123}, 1'b0, "V");
    check_val({exec_use_mem, exec_bit_num}, 32'h15);
    $display("t_fields done");
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    #1;
    fetch_u.push(24'h100001);
    @(posedge core_clk);
    #1;
    rst_n = 1'b0;
    #1;
    check_val({exec_valid, exec_nop, word_ready, exec_redirect, exec_class}, 32'h20);
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    play('{24'h100001}, 1'b0, "V");
    $display("t_reset done");
  endtask

  initial begin
    #(3000 * 100);
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    cond_true = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_single();
    t_cond();
    t_flow();
    t_skip();
    t_movd();
    t_two();
    t_fields();
    t_reset();
    test_done();
  end
endmodule
